// *** include/rtc_pkg.sv ***
// package: register map, field layouts, timing constants and state types of the rtc block
package rtc_pkg;

  localparam int ADDR_W = 12;
  localparam int PERIOD_W = 20;
  localparam int TIME_W = 32;
  localparam int PRE_W = 6;
  localparam int CYC_W = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_LOW_CHAIN = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_TIME = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_ALARM = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_CYCLIC_N = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_EXT_SELECT = 12'h024;

  // event bit positions in status, clear and enable
  localparam int EV_TICK = 0;
  localparam int EV_ALARM = 1;
  localparam int EV_CYCLIC = 2;
  localparam int EV_W = 3;

  // fixed 1/64 pre-division: prescaler wraps after this count
  localparam logic [PRE_W-1:0] PRE_LAST = 6'h3f;

  // low-power oscillator detection after reset
  localparam int CLK_PERIOD_NS = 100;
  localparam int DETECT_TIME_NS = 1000000;
  localparam int DETECT_CYCLES = DETECT_TIME_NS / CLK_PERIOD_NS;
  localparam int DET_W = 24;
  localparam logic [7:0] LP_EDGE_MIN = 8'h10;

  // reset values
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 20'h00000;
  localparam logic [TIME_W-1:0] ALARM_RST = 32'hffffffff;
  localparam logic [CYC_W-1:0] CYC_N_RST = 16'h0000;

  typedef struct packed {
    logic run_in_sleep;
    logic powerdown_wake_cfg;
    logic osc_off_in_sleep;
    logic rtc_enable;
  } clock_unit_control_t;

  localparam clock_unit_control_t CTRL_RST = 4'h1;

  typedef struct packed {
    logic alarm;
    logic tick;
  } ext_irq_select_t;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [PERIOD_W-1:0] div;
    logic [PERIOD_W-1:0] tick_period_value;
    logic [TIME_W-1:0] time_cnt;
    logic [TIME_W-1:0] alarm;
    logic [CYC_W-1:0] cyc_n;
    logic [CYC_W-1:0] cyc_cnt;
    clock_unit_control_t ctrl;
    ext_irq_select_t ext_sel;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] irq_en;
    logic main_prev;
    logic lp_prev;
    logic lp_sel;
    logic detect_done;
    logic [DET_W-1:0] det_cnt;
    logic [7:0] edge_cnt;
    logic tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic wake;
    logic [1:0] ext_irq;
    logic main_osc_en;
    logic lp_osc_en;
  } rtc_state_t;

endpackage

// *** logic/rtc_prescaler_alarm_counter.sv ***
// real-time clock: 1/64 prescaler, reloadable tick divider, time counter, alarm, apb registers
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps

// Operation
// RL1: the clock runs from the main or low-power oscillator input and can keep counting in sleep.
// RL2: the tick divider advances once per 64 edges of the selected input clock.
// RL3: the 20-bit divider reloads from the software period register at every tick.
// RL4: a tick interrupt request is raised once per tick when enabled.
// RL5: a cyclic interrupt is raised every n ticks, n programmable, when enabled.
// RL6: a 32-bit time counter, preloadable by software, advances once per tick.
// RL7: an alarm request is raised when the time counter equals the alarm register.
// RL8: prescaler, divider and time counter together form a readable 58-bit timer.
// RL9: the block wakes the chip from power-down only when the wake configuration bit is set.
// RL10: tick and alarm requests can be routed out as fast external interrupts that wake the chip.
// RL11: with the oscillator-off bit set, the clock oscillator stops on entry to power-down.
// RL12: in power-down with the clock disabled, both oscillators stop.
// RL13: after reset, a running low-power oscillation is detected and then drives the counter.
// RL14: on the low-power source the main oscillator stops in power-down, counting as configured.
// RL15: on the main source the main oscillator keeps running in power-down unless disabled.
// RL16: the registers are reachable by software over the peripheral bus.
// RL17: the divider counts down, and at zero gives a one-cycle tick and reloads.
module rtc_prescaler_alarm_counter
  import rtc_pkg::*;
#(
  parameter int DETECT_CYCLES_P = DETECT_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic main_osc_input,
  input wire logic low_power_osc_input,
  input wire logic powerdown_mode,
  output logic irq,
  output logic tick_irq_request,
  output logic alarm_irq_request,
  output logic wake_request,
  output logic main_osc_enable,
  output logic low_power_osc_enable,
  output logic low_power_source
);

  localparam logic [DET_W-1:0] DET_LAST = DET_W'(DETECT_CYCLES_P - 1);

  rtc_state_t s;
  rtc_state_t next_s;

  logic main_edge;
  logic lp_edge;
  logic src_edge;
  logic run;
  logic tick_ev;
  logic alarm_ev;
  logic cyc_ev;
  logic setup_ph;
  logic wr_en;
  logic [EV_W-1:0] clr;
  logic [EV_W-1:0] ev;
  logic [TIME_W-1:0] time_inc;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    next_s.ext_irq = 2'h0;
    // error flag stands only in the access cycle, like pready
    next_s.pslverr = 1'b0;
    tick_ev = 1'b0;
    alarm_ev = 1'b0;
    cyc_ev = 1'b0;
    clr = '0;
    time_inc = s.time_cnt + 32'h00000001;

    // pin inputs are synchronous; edges on the selected oscillator drive the chain
    main_edge = main_osc_input & ~s.main_prev;
    lp_edge = low_power_osc_input & ~s.lp_prev;
    next_s.main_prev = main_osc_input;
    next_s.lp_prev = low_power_osc_input;

    // source choice is made once after reset; counting waits for it
    if (!s.detect_done) begin
      if (lp_edge && s.edge_cnt != 8'hff) begin
        next_s.edge_cnt = s.edge_cnt + 8'h01;
      end
      if (s.det_cnt == DET_LAST) begin
        next_s.detect_done = 1'b1;
        next_s.lp_sel = (s.edge_cnt >= LP_EDGE_MIN); // RL13
      end else begin
        next_s.det_cnt = s.det_cnt + 24'h000001;
      end
    end

    src_edge = s.lp_sel ? lp_edge : main_edge; // RL1
    // idle does not stop the chain; power-down does unless run_in_sleep
    run = s.detect_done & s.ctrl.rtc_enable & (~powerdown_mode | s.ctrl.run_in_sleep); // RL1 RL14

    if (run && src_edge) begin
      next_s.pre = s.pre + 6'h01; // RL2
      if (s.pre == PRE_LAST) begin
        if (s.div == '0) begin
          next_s.div = s.tick_period_value; // RL3 RL17
          tick_ev = 1'b1; // RL17
        end else begin
          next_s.div = s.div - 20'h00001; // RL17
        end
      end
    end

    if (tick_ev) begin
      next_s.tick = 1'b1;
      next_s.time_cnt = time_inc; // RL6
      alarm_ev = (time_inc == s.alarm); // RL7
      // n of zero disables the cyclic event
      if (s.cyc_n != '0) begin
        if (s.cyc_cnt == s.cyc_n - 16'h0001) begin
          cyc_ev = 1'b1; // RL5
          next_s.cyc_cnt = '0;
        end else begin
          next_s.cyc_cnt = s.cyc_cnt + 16'h0001;
        end
      end
    end

    // apb: setup cycle latches read data, access cycle answers with pready
    setup_ph = psel & ~penable;
    wr_en = psel & penable & s.pready & pwrite;
    next_s.pready = setup_ph; // RL16
    if (setup_ph) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h00000000;
      case (paddr)
        OFS_CONTROL: next_s.prdata = {27'h0, s.lp_sel, s.ctrl};
        OFS_PERIOD: next_s.prdata = {12'h000, s.tick_period_value};
        OFS_LOW_CHAIN: next_s.prdata = {6'h00, s.div, s.pre}; // RL8
        OFS_TIME: next_s.prdata = s.time_cnt;
        OFS_ALARM: next_s.prdata = s.alarm;
        OFS_CYCLIC_N: next_s.prdata = {16'h0000, s.cyc_n};
        OFS_IRQ_STATUS: next_s.prdata = {29'h0, s.status};
        OFS_IRQ_CLEAR: next_s.prdata = 32'h00000000;
        OFS_IRQ_ENABLE: next_s.prdata = {29'h0, s.irq_en};
        OFS_EXT_SELECT: next_s.prdata = {30'h0, s.ext_sel};
        default: next_s.pslverr = 1'b1;
      endcase
    end

    if (wr_en) begin
      case (paddr)
        OFS_CONTROL: next_s.ctrl = pwdata[3:0];
        OFS_PERIOD: next_s.tick_period_value = pwdata[PERIOD_W-1:0]; // RL3
        // preload wins over a tick in the same cycle
        OFS_TIME: next_s.time_cnt = pwdata; // RL6
        OFS_ALARM: next_s.alarm = pwdata; // RL7
        OFS_CYCLIC_N: begin
          next_s.cyc_n = pwdata[CYC_W-1:0]; // RL5
          next_s.cyc_cnt = '0;
        end
        OFS_IRQ_CLEAR: clr = pwdata[EV_W-1:0];
        OFS_IRQ_ENABLE: next_s.irq_en = pwdata[EV_W-1:0];
        OFS_EXT_SELECT: next_s.ext_sel = pwdata[1:0]; // RL10
        default: next_s.ctrl = s.ctrl;
      endcase
    end

    // a new event beats a clear in the same cycle
    ev = {cyc_ev, alarm_ev, tick_ev};
    next_s.status = (s.status & ~clr) | ev; // RL4 RL5 RL7
    next_s.irq = |(next_s.status & s.irq_en); // RL4
    next_s.ext_irq = {alarm_ev & s.ext_sel.alarm, tick_ev & s.ext_sel.tick}; // RL10
    next_s.wake = powerdown_mode & s.ctrl.powerdown_wake_cfg & // RL9
                  (|(next_s.status & s.irq_en) | (|next_s.ext_irq)); // RL10

    // oscillator control in power-down
    next_s.main_osc_en = ~(powerdown_mode & (~s.ctrl.rtc_enable | s.lp_sel | // RL12 RL14 RL15
                                             s.ctrl.osc_off_in_sleep)); // RL11
    next_s.lp_osc_en = ~(powerdown_mode & (~s.ctrl.rtc_enable | // RL12
                                           (s.lp_sel & s.ctrl.osc_off_in_sleep))); // RL11
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.tick_period_value <= PERIOD_RST;
      s.div <= PERIOD_RST;
      s.alarm <= ALARM_RST;
      s.cyc_n <= CYC_N_RST;
      s.ctrl <= CTRL_RST;
      s.main_osc_en <= 1'b1;
      s.lp_osc_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign irq = s.irq;
  assign tick_irq_request = s.ext_irq[0];
  assign alarm_irq_request = s.ext_irq[1];
  assign wake_request = s.wake;
  assign main_osc_enable = s.main_osc_en;
  assign low_power_osc_enable = s.lp_osc_en;
  assign low_power_source = s.lp_sel;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  logic time_wr_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      time_wr_q <= 1'b0;
    end else begin
      time_wr_q <= wr_en && (paddr == OFS_TIME);
    end
  end

  sequence seq_setup;
    psel && !penable;
  endsequence

  sequence seq_sleep_osc_off;
    powerdown_mode && s.ctrl.osc_off_in_sleep;
  endsequence

  chk_tick_reload: assert property (s.tick |-> s.div == $past(s.tick_period_value)) // RL3
    else $error("divider not reloaded from period at tick");
  chk_tick_single: assert property (s.tick |=> !s.tick) // RL17
    else $error("tick wider than one cycle");
  chk_prescale_wrap: assert property (s.tick |-> s.pre == 6'h00 && $past(s.pre) == PRE_LAST) // RL2
    else $error("tick not on prescaler wrap");
  chk_time_advance: assert property (s.tick && !time_wr_q |->
                                     s.time_cnt == $past(s.time_cnt) + 32'h00000001) // RL6
    else $error("time counter did not advance by one");
  chk_alarm_match: assert property (s.tick && !time_wr_q && s.time_cnt == s.alarm |->
                                    s.status[EV_ALARM]) // RL7
    else $error("alarm match without alarm status");
  chk_tick_status: assert property (s.tick |-> s.status[EV_TICK] ##1 irq || !s.irq_en[EV_TICK]
                                    || !s.status[EV_TICK]) // RL4
    else $error("tick did not set status");
  chk_irq_level: assert property (|(s.status & s.irq_en) |=> irq || $past(|clr)) // RL4
    else $error("enabled status without interrupt");
  chk_apb_answer: assert property (seq_setup |=> pready ##1 !pready) // RL16
    else $error("apb answer not one cycle after setup");
  chk_osc_off: assert property (seq_sleep_osc_off |=> !main_osc_enable) // RL11
    else $error("main oscillator left on with osc_off in sleep");
  chk_full_off: assert property (powerdown_mode && !s.ctrl.rtc_enable |=>
                                 !main_osc_enable && !low_power_osc_enable) // RL12
    else $error("oscillators left on with clock disabled in sleep");
  chk_wake_gate: assert property (!s.ctrl.powerdown_wake_cfg || !powerdown_mode |=>
                                  !wake_request) // RL9
    else $error("wake without wake configuration");
  chk_lp_sleep: assert property (s.lp_sel && powerdown_mode |=> !main_osc_enable) // RL14
    else $error("main oscillator on in sleep with low-power source");

  // bus side: one answer per setup, error only beside it
  sequence seq_access_follows;
    ##1 (pready && psel && penable);
  endsequence

  sequence seq_irq_follows;
    ##1 irq;
  endsequence

  sequence seq_unmapped_setup;
    psel && !penable && paddr > OFS_EXT_SELECT;
  endsequence

  chk_pready_pulse: assert property (pready |=> !pready) // RL16
    else $error("pready held longer than one cycle");
  chk_pready_cause: assert property (pready |-> $past(psel && !penable)) // RL16
    else $error("pready without preceding setup");
  chk_slverr_ready: assert property (pslverr |-> pready) // RL16
    else $error("slave error outside the answer cycle");
  chk_unmapped_err: assert property (seq_unmapped_setup |=> pslverr && prdata == 32'h0) // RL16
    else $error("unmapped address not refused");
  chk_mapped_ok: assert property (seq_setup && paddr <= OFS_EXT_SELECT && paddr[1:0] == 2'h0 // RL16
                                  |=> !pslverr)
    else $error("mapped address refused");
  chk_access_phase: assert property (seq_setup |-> seq_access_follows) // RL16
    else $error("setup not followed by an answered access");
  chk_clear_reads: assert property (seq_setup && paddr == OFS_IRQ_CLEAR |=> prdata == 32'h0) // RL16
    else $error("clear register read not zero");

  // register writes land at the access edge
  chk_period_write: assert property (wr_en && paddr == OFS_PERIOD |=> // RL3
                                     s.tick_period_value == $past(pwdata[PERIOD_W-1:0]))
    else $error("period write lost");
  chk_time_preload: assert property (wr_en && paddr == OFS_TIME |=> // RL6
                                     s.time_cnt == $past(pwdata))
    else $error("time preload lost");
  chk_alarm_write: assert property (wr_en && paddr == OFS_ALARM |=> // RL7
                                    s.alarm == $past(pwdata))
    else $error("alarm write lost");
  chk_ctrl_write: assert property (wr_en && paddr == OFS_CONTROL |=> // RL1
                                   s.ctrl == $past(pwdata[3:0]))
    else $error("control write lost");
  chk_clear_bits: assert property (wr_en && paddr == OFS_IRQ_CLEAR && !(|ev) |=> // RL4
                                   (s.status & $past(pwdata[EV_W-1:0])) == 3'h0)
    else $error("status bit survived a clear");

  // events and their requests
  chk_event_wins: assert property (tick_ev |=> s.status[EV_TICK]) // RL4
    else $error("tick event lost against a clear");
  chk_irq_quiet: assert property (s.irq_en == 3'h0 |=> !irq) // RL4
    else $error("interrupt with nothing enabled");
  chk_tick_irq: assert property (s.tick && s.irq_en[EV_TICK] && !clr[EV_TICK] |-> // RL4
                                 seq_irq_follows)
    else $error("enabled tick gave no interrupt");
  chk_cyclic_gate: assert property (s.cyc_n == 16'h0000 |-> !cyc_ev) // RL5
    else $error("cyclic event while n is zero");
  chk_cyclic_tick: assert property (cyc_ev |-> tick_ev) // RL5
    else $error("cyclic event off a tick");
  chk_ext_tick: assert property (tick_irq_request |-> s.tick) // RL10
    else $error("external tick request without tick");
  chk_ext_alarm: assert property (alarm_irq_request |-> s.status[EV_ALARM]) // RL10
    else $error("external alarm request without alarm status");
  chk_ext_pulse: assert property (tick_irq_request |=> !tick_irq_request) // RL10
    else $error("external tick request wider than one cycle");
  chk_wake_alarm: assert property (powerdown_mode && s.ctrl.powerdown_wake_cfg && // RL9
                                   s.irq_en[EV_ALARM] && alarm_ev |=> wake_request)
    else $error("enabled alarm did not wake");

  // counting chain
  chk_prescale_step: assert property (run && src_edge |=> s.pre == $past(s.pre) + 6'h01) // RL2
    else $error("prescaler did not step on a source edge");
  chk_div_count: assert property (run && src_edge && s.pre == PRE_LAST && s.div != 20'h00000 // RL17
                                  |=> s.div == $past(s.div) - 20'h00001)
    else $error("divider did not count down");
  chk_stopped: assert property (!run && !wr_en |=> $stable(s.time_cnt) && $stable(s.pre)) // RL1
    else $error("chain moved while stopped");
  chk_detect_wait: assert property (!s.detect_done |-> s.pre == 6'h00 && !s.tick) // RL13
    else $error("counting before source detection");
  chk_source_fixed: assert property (s.detect_done |=> $stable(s.lp_sel)) // RL13
    else $error("source changed after detection");

  // oscillator control
  chk_awake_osc: assert property (!powerdown_mode |=> main_osc_enable && low_power_osc_enable) // RL15
    else $error("oscillator stopped outside power-down");
  chk_main_keep: assert property (powerdown_mode && !s.lp_sel && s.ctrl.rtc_enable && // RL15
                                  !s.ctrl.osc_off_in_sleep |=> main_osc_enable)
    else $error("main source stopped in sleep while enabled");
  chk_lp_keep: assert property (powerdown_mode && s.ctrl.rtc_enable && // RL14
                                !s.ctrl.osc_off_in_sleep |=> low_power_osc_enable)
    else $error("low-power oscillator stopped in sleep");

endmodule

// *** tb/rtc_prescaler_alarm_counter_tb.sv ***
// self-checking testbench of the rtc block over its apb registers
`timescale 1ns/1ps
module rtc_prescaler_alarm_counter_tb;
  import rtc_pkg::*;

  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic main_osc_input = 1'b0;
  logic low_power_osc_input = 1'b0;
  logic powerdown_mode = 1'b0;
  logic lp_run = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic tick_irq_request;
  logic alarm_irq_request;
  logic wake_request;
  logic main_osc_enable;
  logic low_power_osc_enable;
  logic low_power_source;
  logic [31:0] rdata;
  logic rerr;
  int mismatches = 0;
  int n_compared = 0;
  int gap;
  int cyc = 0;
  int last_ev = 0;
  logic [3:0] ctrl_tab [4] = '{4'h5, 4'h1, 4'h3, 4'h0};
  logic [2:0] osc_tab [4] = '{3'b111, 3'b011, 3'b001, 3'b000};

  // short detection window so the run stays brief
  rtc_prescaler_alarm_counter #(.DETECT_CYCLES_P(64)) rtc_prescaler_alarm_counter_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_osc_input(main_osc_input),
    .low_power_osc_input(low_power_osc_input), .powerdown_mode(powerdown_mode),
    .irq(irq), .tick_irq_request(tick_irq_request),
    .alarm_irq_request(alarm_irq_request), .wake_request(wake_request),
    .main_osc_enable(main_osc_enable), .low_power_osc_enable(low_power_osc_enable),
    .low_power_source(low_power_source)
  );

  always #50 core_clk = ~core_clk;

  // main source: one rising edge every two core cycles
  always @(posedge core_clk) begin
    main_osc_input <= ~main_osc_input;
    low_power_osc_input <= lp_run ? ~low_power_osc_input : 1'b0;
    cyc <= cyc + 1;
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string name);
    xfer(1'b0, a, 32'h00000000);
    check(name, rdata, exp);
  endtask

  // waits for a tick (0) or alarm (1) pulse; gap is cycles since the previous pulse
  task automatic wait_ev(input int which);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (((which != 0) ? alarm_irq_request : tick_irq_request) !== 1'b1 && n < 3000);
    if (n >= 3000) mismatches++;
    gap = cyc - last_ev;
    last_ev = cyc;
  endtask

  initial begin
    #2000000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_CONTROL, 32'h00000001, "control reset");
    check("read error", {31'h0, rerr}, 32'h0);
    rd(OFS_PERIOD, 32'h00000000, "period reset");
    rd(OFS_ALARM, 32'hffffffff, "alarm reset");
    rd(OFS_CYCLIC_N, 32'h00000000, "cyclic reset");
    check("osc enables", {30'h0, main_osc_enable, low_power_osc_enable}, 32'h3);
    // pulses only leave the block once routed out
    wr(OFS_EXT_SELECT, 32'h00000003);
    wait_ev(0);
    wr(OFS_PERIOD, 32'h00000001);
    wr(OFS_IRQ_ENABLE, 32'h00000007);
    wr(OFS_EXT_SELECT, 32'h00000003);
    wr(OFS_TIME, 32'h00000005);
    wr(OFS_ALARM, 32'h00000008);
    wr(OFS_CYCLIC_N, 32'h00000002);
    wr(OFS_IRQ_CLEAR, 32'h00000007);
    wait_ev(0);
    rd(OFS_TIME, 32'h00000006, "time first tick");
    rd(OFS_IRQ_STATUS, 32'h00000001, "status first tick");
    wr(OFS_IRQ_CLEAR, 32'h00000007);
    wait_ev(0);
    // 64 prescale steps of two core cycles, times period plus one
    check("tick gap", gap, 32'd256);
    rd(OFS_TIME, 32'h00000007, "time second tick");
    rd(OFS_IRQ_STATUS, 32'h00000005, "status cyclic");
    wr(OFS_IRQ_CLEAR, 32'h00000007);
    wait_ev(1);
    check("alarm gap", gap, 32'd256);
    rd(OFS_TIME, 32'h00000008, "time at alarm");
    rd(OFS_IRQ_STATUS, 32'h00000003, "status alarm");
    check("irq level", {31'h0, irq}, 32'h1);
    powerdown_mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CONTROL, {28'h0, ctrl_tab[i]});
      repeat (3) @(posedge core_clk);
      check("sleep outputs", {29'h0, wake_request, main_osc_enable, low_power_osc_enable},
            {29'h0, osc_tab[i]});
    end
    powerdown_mode <= 1'b0;
    wr(OFS_CONTROL, 32'h00000001);
    wait_ev(0);
    wr(OFS_IRQ_CLEAR, 32'h00000007);
    rd(OFS_IRQ_STATUS, 32'h00000000, "status cleared");
    check("irq dropped", {31'h0, irq}, 32'h0);
    rd(OFS_IRQ_CLEAR, 32'h00000000, "clear reads zero");
    rd(12'h030, 32'h00000000, "unmapped data");
    check("unmapped error", {31'h0, rerr}, 32'h1);
    // second reset with a running low-power oscillation
    lp_run <= 1'b1;
    sys_rst <= 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (100) @(posedge core_clk);
    check("lp source", {31'h0, low_power_source}, 32'h1);
    rd(OFS_CONTROL, 32'h00000011, "control lp source");
    powerdown_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("lp sleep osc", {30'h0, main_osc_enable, low_power_osc_enable}, 32'h1);
    tally_and_finish();
  end
endmodule
